// [logic/atten_round.sv]
// Rounds a requested attenuation in dB to the nearest 10 dB step index
module atten_round
    import rcd_pkg::*;
#(
    parameter int MAX_IDX = ATTEN_MAX_IDX
) (
    input wire logic signed [15:0] i_db,
    output logic [3:0] o_idx
);
    logic [15:0] mag;
    logic [15:0] idx_full;
    initial begin
        if (MAX_IDX < 1 || MAX_IDX > 15) begin
            $error("atten_round: MAX_IDX out of range");
        end
    end
    always_comb begin
        mag = (i_db < 0) ? 16'(-i_db) : 16'h0000;
        idx_full = 16'((32'(mag) + 32'(ATTEN_STEP_DB / 2)) / 32'(ATTEN_STEP_DB));
        if (idx_full > 16'(MAX_IDX)) begin
            o_idx = 4'(MAX_IDX);
        end else begin
            o_idx = idx_full[3:0];
        end
    end
endmodule // atten_round

// [logic/rcd_pkg.sv]
// Shared constants and types for the remote command decoder
package rcd_pkg;
    localparam int FREQ_W = 48;
    localparam int FP_MAX_LEN = 14;
    localparam int ATTEN_STEP_DB = 10;
    localparam int ATTEN_MAX_IDX = 9;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STEP = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CW_LO = 8'h0c;
    localparam logic [7:0] OFS_CW_HI = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h14;
    localparam int CTRL_REMOTE_BIT = 0;
    localparam int CTRL_AUTO_BC_DIS_BIT = 1;
    localparam int CTRL_DECOUPLE_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int CFG_NA_BIT = 0;
    localparam int CFG_KB_HOLD_BIT = 1;
    localparam int CFG_NO_SYNERR_BIT = 2;
    localparam logic [31:0] STEP_RESET = 32'h0000_0000;
    localparam logic [4:0] FUNC_NONE = 5'h00;
    typedef enum logic [3:0] {
        CMD_FUNC = 4'h0,
        CMD_ATTEN = 4'h1,
        CMD_BAND = 4'h2,
        CMD_CLEAR = 4'h3,
        CMD_DISPLAY = 4'h4,
        CMD_KNOB = 4'h5,
        CMD_FAST = 4'h6,
        CMD_INCR = 4'h7,
        CMD_LEARN = 4'h8,
        CMD_KBREL = 4'h9,
        CMD_CONFIG = 4'ha,
        CMD_ALTSEL = 4'hb
    } cmd_code_t;
endpackage

// [logic/remote_command_decoder.sv]
// Remote command decoder with classic Wishbone register access
// What this block does
// - Attenuator spans 0 to -90 dB in 10 dB steps only.
// - Off-step attenuator requests round to nearest 10 dB step.
// - Band advance acts in analyzer mode or with auto bandcross off.
// - With auto bandcross off, band advance equals manual bandcross step.
// - Clear status zeroes all sixteen status bits except those set in the same cycle.
// - Clear status also cancels deferred status bits.
// - Display command blanks with 0, unblanks with 1.
// - Unblank during sweep stops, retraces and resumes the sweep.
// - Knob enable ties knob to most recently active function.
// - Bare function code activates it and restores last value.
// - Fast lock disables plotter, freezes ramp, releases handshake early.
// - Fast lock suffix in Hz, at most 14 chars, line feed only.
// - Increment steps fixed frequency, triggers step sweep, not fast lock.
// - Learn restore reactivates stored function; memory recall leaves none.
// - Config bit 1 locks keyboard after a key until release command.
// - Config bit 0 enables analyzer mode and its detection changes.
// - Analyzer mode: binary search, end-of-sweep request, no auto alternation when nonswept.
// - Analyzer mode ignores band advance after mid-sweep update until trigger.
// - Config bit 2 suppresses the syntax-error annunciator.
// - Config byte bits 0 to 2 weigh 1, 2, 4; bits 3-7 unused.
// - State select halts, retraces to chosen state, resumes alternation.
// - Knob disabled under remote unless enabled by command.
//
// Chosen here: the register addresses and register access over Wishbone.
module remote_command_decoder
    import rcd_pkg::*;
#(
    parameter int FW = FREQ_W
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    input wire logic I_CMD_VALID,
    input wire logic [3:0] I_CMD_CODE,
    input wire logic [4:0] I_CMD_FUNC,
    input wire logic I_CMD_HAS_ARG,
    input wire logic [FW-1:0] I_CMD_ARG,
    input wire logic [4:0] I_CMD_ARG_LEN,
    input wire logic I_CMD_LF_TERM,
    input wire logic I_CMD_BAD,
    input wire logic I_BUS_TRIGGER,
    input wire logic I_RECALL,
    input wire logic I_MIDSWEEP_UPDATE,
    input wire logic I_SWEEPING,
    input wire logic I_ALT_ACTIVE,
    input wire logic I_NONSWEPT,
    input wire logic I_PLL_LOCKED,
    input wire logic I_FUNC_DONE,
    input wire logic [15:0] I_STATUS_SET,
    input wire logic [15:0] I_STATUS_DEFER,
    input wire logic I_KEY_PRESS,
    output logic [3:0] O_ATTEN_STEP,
    output logic O_BAND_ADVANCE,
    output logic O_DISPLAY_BLANK,
    output logic O_SWEEP_RETRACE,
    output logic O_SWEEP_START,
    output logic O_KNOB_EN,
    output logic [4:0] O_ACTIVE_FUNC,
    output logic O_FUNC_RESTORE,
    output logic O_FAST_LOCK,
    output logic O_HS_RELEASE,
    output logic [FW-1:0] O_CW_FREQ,
    output logic O_STEP_SWEEP_TRIG,
    output logic O_KB_LOCKED,
    output logic O_NA_MODE,
    output logic O_EOS_SRQ,
    output logic O_ALT_AUTO_SUPPRESS,
    output logic O_SYNERR_ANN,
    output logic O_RETRACE_FG,
    output logic O_RETRACE_BG,
    output logic [15:0] O_STATUS
);
    initial begin
        if (FW < 33 || FW > 64) begin
            $error("remote_command_decoder: FW out of range");
        end
    end

    logic [2:0] ctrl_reg;
    logic [31:0] step_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [3:0] atten_reg;
    logic [3:0] atten_next;
    logic band_reg;
    logic blank_reg;
    logic retrace_reg;
    logic start_reg;
    logic knob_reg;
    logic [4:0] func_reg;
    logic restore_reg;
    logic fast_reg;
    logic hs_pend_reg;
    logic hs_rel_reg;
    logic [FW-1:0] cw_reg;
    logic stepsw_reg;
    logic kb_lock_reg;
    logic [2:0] cfg_reg;
    logic bc_block_reg;
    logic srq_reg;
    logic synerr_reg;
    logic fg_reg;
    logic bg_reg;
    logic [15:0] status_reg;
    logic [15:0] pend_reg;
    logic key_meta_reg;
    logic key_sync_reg;
    logic key_prev_reg;
    logic key_rise;
    logic cmd_ok;
    logic is_clear;
    logic fast_ok;
    logic bc_allowed;

    function automatic logic cmd_is(input logic [3:0] code, input cmd_code_t c);
        cmd_is = (code == c);
    endfunction

    assign cmd_ok = I_CMD_VALID && !I_CMD_BAD;
    assign is_clear = cmd_ok && cmd_is(I_CMD_CODE, CMD_CLEAR);
    assign fast_ok = I_CMD_HAS_ARG && I_CMD_LF_TERM && (I_CMD_ARG_LEN <= 5'(FP_MAX_LEN));
    assign bc_allowed = cfg_reg[CFG_NA_BIT] ? !bc_block_reg : ctrl_reg[CTRL_AUTO_BC_DIS_BIT];
    assign key_rise = key_sync_reg && !key_prev_reg;

    atten_round u_round (
        .i_db(I_CMD_ARG[15:0]),
        .o_idx(atten_next)
    );

    // Wishbone slave: ack one cycle after the request, dropped next cycle
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            ctrl_reg <= CTRL_RESET;
            step_reg <= STEP_RESET;
        end else begin
            ack_reg <= I_WB_CYC && I_WB_STB && !ack_reg;
            if (I_WB_CYC && I_WB_STB && !ack_reg && I_WB_WE) begin
                if (I_WB_ADR == OFS_CTRL && I_WB_SEL[0]) begin
                    ctrl_reg <= I_WB_DAT[2:0];
                end
                if (I_WB_ADR == OFS_STEP) begin
                    for (int b = 0; b < 4; b++) begin
                        if (I_WB_SEL[b]) begin
                            step_reg[b*8 +: 8] <= I_WB_DAT[b*8 +: 8];
                        end
                    end
                end
            end
            if (I_WB_CYC && I_WB_STB && !ack_reg && !I_WB_WE) begin
                unique case (I_WB_ADR)
                    OFS_CTRL: rdat_reg <= {29'h0, ctrl_reg};
                    OFS_STEP: rdat_reg <= step_reg;
                    OFS_STATUS: rdat_reg <= {pend_reg, status_reg};
                    OFS_CW_LO: rdat_reg <= cw_reg[31:0];
                    OFS_CW_HI: rdat_reg <= 32'(cw_reg[FW-1:32]);
                    OFS_MODE: rdat_reg <= {16'h0000, kb_lock_reg, fast_reg, knob_reg, blank_reg,
                        func_reg, cfg_reg, atten_reg};
                    default: rdat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign O_WB_ACK = ack_reg;
    assign O_WB_DAT = rdat_reg;

    // Attenuator step
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            atten_reg <= 4'h0;
        end else if (cmd_ok && cmd_is(I_CMD_CODE, CMD_ATTEN) && I_CMD_HAS_ARG) begin
            atten_reg <= atten_next;
        end
    end

    // Band advance, display, retrace and alternation pulses
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            band_reg <= 1'b0;
            blank_reg <= 1'b0;
            retrace_reg <= 1'b0;
            fg_reg <= 1'b0;
            bg_reg <= 1'b0;
        end else begin
            band_reg <= cmd_ok && cmd_is(I_CMD_CODE, CMD_BAND) && bc_allowed;
            retrace_reg <= 1'b0;
            fg_reg <= 1'b0;
            bg_reg <= 1'b0;
            if (cmd_ok && cmd_is(I_CMD_CODE, CMD_DISPLAY)) begin
                blank_reg <= !I_CMD_ARG[0];
                retrace_reg <= I_CMD_ARG[0] && I_SWEEPING;
            end
            if (cmd_ok && cmd_is(I_CMD_CODE, CMD_ALTSEL) && I_ALT_ACTIVE) begin
                fg_reg <= !I_CMD_ARG[0];
                bg_reg <= I_CMD_ARG[0];
            end
        end
    end

    // Knob enable and active function
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            knob_reg <= 1'b0;
            func_reg <= FUNC_NONE;
            restore_reg <= 1'b0;
        end else begin
            restore_reg <= 1'b0;
            if (cmd_ok && cmd_is(I_CMD_CODE, CMD_KNOB)) begin
                knob_reg <= 1'b1;
            end else if (!ctrl_reg[CTRL_REMOTE_BIT]) begin
                knob_reg <= 1'b0;
            end
            if (I_RECALL) begin
                func_reg <= FUNC_NONE;
            end else if (cmd_ok && cmd_is(I_CMD_CODE, CMD_FUNC)) begin
                func_reg <= I_CMD_FUNC;
                restore_reg <= !I_CMD_HAS_ARG;
            end else if (cmd_ok && cmd_is(I_CMD_CODE, CMD_LEARN)) begin
                func_reg <= I_CMD_ARG[4:0];
            end
        end
    end
    assign O_KNOB_EN = knob_reg || !ctrl_reg[CTRL_REMOTE_BIT];

    // Fast lock, fixed frequency stepping and handshake release
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            fast_reg <= 1'b0;
            cw_reg <= '0;
            stepsw_reg <= 1'b0;
            hs_pend_reg <= 1'b0;
            hs_rel_reg <= 1'b0;
        end else begin
            stepsw_reg <= 1'b0;
            if (cmd_ok && cmd_is(I_CMD_CODE, CMD_FAST) && fast_ok) begin
                fast_reg <= 1'b1;
                cw_reg <= I_CMD_ARG;
            end else if (cmd_ok && cmd_is(I_CMD_CODE, CMD_FUNC)) begin
                fast_reg <= 1'b0;
            end else if (cmd_ok && cmd_is(I_CMD_CODE, CMD_INCR) && !fast_reg) begin
                cw_reg <= cw_reg + FW'(step_reg);
                stepsw_reg <= 1'b1;
            end else if (I_BUS_TRIGGER && fast_reg) begin
                cw_reg <= cw_reg + FW'(step_reg);
            end
            hs_rel_reg <= 1'b0;
            if (I_CMD_VALID && fast_reg) begin
                hs_rel_reg <= 1'b1;
                hs_pend_reg <= 1'b0;
            end else if (I_CMD_VALID) begin
                hs_pend_reg <= 1'b1;
            end else if (hs_pend_reg && (I_PLL_LOCKED || fast_reg)) begin
                hs_rel_reg <= 1'b1;
                hs_pend_reg <= 1'b0;
            end
        end
    end

    // Configuration byte, analyzer mode state and syntax annunciator
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cfg_reg <= 3'h0;
            bc_block_reg <= 1'b0;
            srq_reg <= 1'b0;
            start_reg <= 1'b0;
            synerr_reg <= 1'b0;
        end else begin
            if (cmd_ok && cmd_is(I_CMD_CODE, CMD_CONFIG)) begin
                cfg_reg <= I_CMD_ARG[2:0];
            end
            srq_reg <= cfg_reg[CFG_NA_BIT] && I_MIDSWEEP_UPDATE;
            start_reg <= cfg_reg[CFG_NA_BIT] && I_BUS_TRIGGER && bc_block_reg;
            if (I_MIDSWEEP_UPDATE && cfg_reg[CFG_NA_BIT]) begin
                bc_block_reg <= 1'b1;
            end else if (I_BUS_TRIGGER || !cfg_reg[CFG_NA_BIT]) begin
                bc_block_reg <= 1'b0;
            end
            if (I_CMD_VALID && I_CMD_BAD && !cfg_reg[CFG_NO_SYNERR_BIT]) begin
                synerr_reg <= 1'b1;
            end else if (cmd_ok || cfg_reg[CFG_NO_SYNERR_BIT]) begin
                synerr_reg <= 1'b0;
            end
        end
    end

    // Keyboard hold-off
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            key_meta_reg <= 1'b0;
            key_sync_reg <= 1'b0;
            key_prev_reg <= 1'b0;
            kb_lock_reg <= 1'b0;
        end else begin
            key_meta_reg <= I_KEY_PRESS;
            key_sync_reg <= key_meta_reg;
            key_prev_reg <= key_sync_reg;
            if (key_rise && cfg_reg[CFG_KB_HOLD_BIT]) begin
                kb_lock_reg <= 1'b1;
            end else if ((cmd_ok && cmd_is(I_CMD_CODE, CMD_KBREL)) || !cfg_reg[CFG_KB_HOLD_BIT]) begin
                kb_lock_reg <= 1'b0;
            end
        end
    end

    // Status bytes with deferred bits; a set beats a clear
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            status_reg <= 16'h0000;
            pend_reg <= 16'h0000;
        end else begin
            if (is_clear) begin
                status_reg <= I_STATUS_SET;
                pend_reg <= I_STATUS_DEFER;
            end else if (I_FUNC_DONE) begin
                status_reg <= status_reg | I_STATUS_SET | pend_reg;
                pend_reg <= I_STATUS_DEFER;
            end else begin
                status_reg <= status_reg | I_STATUS_SET;
                pend_reg <= pend_reg | I_STATUS_DEFER;
            end
        end
    end

    assign O_ATTEN_STEP = atten_reg;
    assign O_BAND_ADVANCE = band_reg;
    assign O_DISPLAY_BLANK = blank_reg;
    assign O_SWEEP_RETRACE = retrace_reg;
    assign O_SWEEP_START = start_reg;
    assign O_ACTIVE_FUNC = func_reg;
    assign O_FUNC_RESTORE = restore_reg;
    assign O_FAST_LOCK = fast_reg;
    assign O_HS_RELEASE = hs_rel_reg;
    assign O_CW_FREQ = cw_reg;
    assign O_STEP_SWEEP_TRIG = stepsw_reg;
    assign O_KB_LOCKED = kb_lock_reg;
    assign O_NA_MODE = cfg_reg[CFG_NA_BIT];
    assign O_EOS_SRQ = srq_reg;
    assign O_ALT_AUTO_SUPPRESS = cfg_reg[CFG_NA_BIT] && I_NONSWEPT;
    assign O_SYNERR_ANN = synerr_reg;
    assign O_RETRACE_FG = fg_reg;
    assign O_RETRACE_BG = bg_reg;
    assign O_STATUS = status_reg;

    // Checks
    sequence s_key_locks;
        cfg_reg[CFG_KB_HOLD_BIT] && key_rise ##1 kb_lock_reg;
    endsequence
    sequence s_no_release;
        !(I_CMD_VALID && cmd_is(I_CMD_CODE, CMD_KBREL));
    endsequence

    property p_atten_range;
        @(posedge I_REF_CLK) disable iff (!I_RESETN) atten_reg <= 4'(ATTEN_MAX_IDX);
    endproperty
    a_atten_range: assert property (p_atten_range) else $error("attenuator index out of range");

    property p_atten_round;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        cmd_ok && cmd_is(I_CMD_CODE, CMD_ATTEN) && I_CMD_HAS_ARG
            && I_CMD_ARG[15:0] == 16'hffd8 |=> atten_reg == 4'h4;
    endproperty
    a_atten_round: assert property (p_atten_round) else $error("minus 40 dB not step 4");

    property p_bc_gate;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_CMD_VALID && cmd_is(I_CMD_CODE, CMD_BAND) && !cfg_reg[CFG_NA_BIT]
            && !ctrl_reg[CTRL_AUTO_BC_DIS_BIT] |=> !band_reg;
    endproperty
    a_bc_gate: assert property (p_bc_gate) else $error("band advance with auto bandcross");

    property p_bc_block;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        cfg_reg[CFG_NA_BIT] && I_MIDSWEEP_UPDATE ##1 !I_BUS_TRIGGER
            ##1 (cfg_reg[CFG_NA_BIT] && I_CMD_VALID
            && cmd_is(I_CMD_CODE, CMD_BAND)) |=> !band_reg;
    endproperty
    a_bc_block: assert property (p_bc_block) else $error("band advance after mid-sweep update");

    property p_clear_status;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        is_clear && I_STATUS_SET == 16'h0000 && I_STATUS_DEFER == 16'h0000
            ##1 I_STATUS_SET == 16'h0000 |=> status_reg == 16'h0000;
    endproperty
    a_clear_status: assert property (p_clear_status) else $error("deferred bit survived clear");

    property p_unblank_retrace;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        cmd_ok && cmd_is(I_CMD_CODE, CMD_DISPLAY) && I_CMD_ARG[0] && I_SWEEPING
            |=> retrace_reg && !blank_reg ##1 !retrace_reg;
    endproperty
    a_unblank_retrace: assert property (p_unblank_retrace) else $error("no retrace on unblank");

    property p_knob_remote;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        ctrl_reg[CTRL_REMOTE_BIT] && !knob_reg |-> !O_KNOB_EN;
    endproperty
    a_knob_remote: assert property (p_knob_remote) else $error("knob live under remote");

    property p_fast_release;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        fast_reg && I_CMD_VALID && !I_PLL_LOCKED |=> hs_rel_reg;
    endproperty
    a_fast_release: assert property (p_fast_release) else $error("handshake waited for lock");

    property p_fast_len;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        !fast_reg && I_CMD_VALID && cmd_is(I_CMD_CODE, CMD_FAST)
            && I_CMD_ARG_LEN > 5'(FP_MAX_LEN) |=> !fast_reg;
    endproperty
    a_fast_len: assert property (p_fast_len) else $error("overlong fast lock suffix taken");

    property p_trig_step;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        fast_reg && I_BUS_TRIGGER && !I_CMD_VALID |=> cw_reg == $past(cw_reg) + FW'(step_reg);
    endproperty
    a_trig_step: assert property (p_trig_step) else $error("trigger did not step frequency");

    property p_kb_hold;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
        s_key_locks ##0 (s_no_release and cfg_reg[CFG_KB_HOLD_BIT]) |=> kb_lock_reg;
    endproperty
    a_kb_hold: assert property (p_kb_hold) else $error("keyboard unlocked without release");

endmodule // remote_command_decoder

// [testbench/host_model.sv]
// Host-side bus controller model that issues parsed commands
module host_model
    import rcd_pkg::*;
(
    input wire logic i_clk,
    output logic o_valid = 1'b0,
    output logic [3:0] o_code = 4'h0,
    output logic [4:0] o_func = 5'h0,
    output logic o_has = 1'b0,
    output logic [FREQ_W-1:0] o_arg = '0,
    output logic [4:0] o_len = 5'h0,
    output logic o_lf = 1'b0,
    output logic o_bad = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic send(logic [3:0] k, logic [FREQ_W-1:0] a, logic [4:0] n, logic b);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_code <= k;
        o_func <= a[4:0];
        o_has <= (n != 5'h0);
        o_arg <= a;
        o_len <= n;
        o_lf <= 1'b1;
        o_bad <= b;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_arg <= ~a;
        o_func <= ~a[4:0];
        o_bad <= 1'b0;
    endtask
endmodule // host_model

// [testbench/tb_top.sv]
// Self-checking bench for the remote command decoder
module tb_top
    import rcd_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(g, x) begin \
        checked++; \
        if ((g) !== (x)) begin \
            error_cnt++; \
            $display("unexpected at %0t: got %h want %h", $time, g, x); \
        end \
    end
    typedef struct {int p; int w; logic [47:0] v;} exp_t;
    exp_t q[$];
    int error_cnt = 0;
    int checked = 0;
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic trig = 1'b0, recall = 1'b0, mid = 1'b0, sweeping = 1'b0, alt = 1'b0;
    logic nonswept = 1'b0, fdone = 1'b0, key = 1'b0, pll = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] dat = 32'h0, rdv = 32'h0, st;
    logic [15:0] sset = 16'h0, sdefer = 16'h0;
    logic [47:0] f;
    wire ack, valid, has, lf, bad;
    wire [31:0] rdat;
    wire [3:0] code;
    wire [4:0] fn, len;
    wire [47:0] arg;
    wire [88:0] o;
    wire [136:0] obs = {16'h0, rdv, o};
    int db[7] = '{0, -40, -45, -44, -90, -95, 20};
    logic [3:0] ix[7] = '{4'h0, 4'h4, 4'h5, 4'h4, 4'h9, 4'h9, 4'h0};
    host_model u_host (.i_clk(clk), .o_valid(valid), .o_code(code), .o_func(fn), .o_has(has),
        .o_arg(arg), .o_len(len), .o_lf(lf), .o_bad(bad));
    remote_command_decoder #(.FW(FREQ_W)) uut (.I_REF_CLK(clk), .I_RESETN(rstn), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(dat),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_CMD_VALID(valid), .I_CMD_CODE(code),
        .I_CMD_FUNC(fn), .I_CMD_HAS_ARG(has), .I_CMD_ARG(arg), .I_CMD_ARG_LEN(len),
        .I_CMD_LF_TERM(lf), .I_CMD_BAD(bad), .I_BUS_TRIGGER(trig), .I_RECALL(recall),
        .I_MIDSWEEP_UPDATE(mid), .I_SWEEPING(sweeping), .I_ALT_ACTIVE(alt),
        .I_NONSWEPT(nonswept), .I_PLL_LOCKED(pll), .I_FUNC_DONE(fdone), .I_STATUS_SET(sset),
        .I_STATUS_DEFER(sdefer), .I_KEY_PRESS(key), .O_ATTEN_STEP(o[19:16]),
        .O_BAND_ADVANCE(o[15]), .O_DISPLAY_BLANK(o[14]), .O_SWEEP_RETRACE(o[13]),
        .O_SWEEP_START(o[12]), .O_KNOB_EN(o[11]), .O_ACTIVE_FUNC(o[24:20]),
        .O_FUNC_RESTORE(o[10]), .O_FAST_LOCK(o[9]), .O_HS_RELEASE(o[8]), .O_CW_FREQ(o[88:41]),
        .O_STEP_SWEEP_TRIG(o[7]), .O_KB_LOCKED(o[6]), .O_NA_MODE(o[5]), .O_EOS_SRQ(o[4]),
        .O_ALT_AUTO_SUPPRESS(o[3]), .O_SYNERR_ANN(o[2]), .O_RETRACE_FG(o[1]),
        .O_RETRACE_BG(o[0]), .O_STATUS(o[40:25]));
    always #5 clk = ~clk;
    task automatic want(int p, int w, logic [47:0] v);
        q.push_back('{p, w, v});
    endtask
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        if (!w) rdv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] v);
        wb(1'b0, a, 32'h0);
        want(89, 32, v);
    endtask
    task automatic c(logic [3:0] k, logic [47:0] a, logic [4:0] n = 5'h2, logic b = 1'b0);
        u_host.send(k, a, n, b);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(negedge clk) begin : mon
        exp_t e;
        while (q.size() > 0) begin
            e = q.pop_front();
            `CHK(obs[e.p +: 48] & ((48'h1 << e.w) - 48'h1), e.v)
        end
    end
    initial begin
        #50us;
        error_cnt++;
        results();
    end
    initial begin : main
        void'($urandom(32'h1f99));
        st = $urandom();
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        want(11, 1, 1);
        rd(OFS_CTRL, {29'h0, CTRL_RESET});
        rd(OFS_STEP, STEP_RESET);
        rd(8'h1c, 32'h0);
        wb(1'b1, OFS_STEP, st);
        rd(OFS_STEP, st);
        wb(1'b1, OFS_CTRL, 32'h5);
        want(11, 1, 0);
        foreach (db[i]) begin
            c(CMD_ATTEN, 48'(db[i]));
            want(16, 4, ix[i]);
        end
        sset <= st[15:0];
        sdefer <= st[31:16];
        @(posedge clk);
        sset <= 16'h0;
        sdefer <= 16'h0;
        want(25, 16, st[15:0]);
        c(CMD_CLEAR, 0, 0);
        want(25, 16, 0);
        fdone <= 1'b1;
        @(posedge clk);
        fdone <= 1'b0;
        want(25, 16, 0);
        rd(OFS_STATUS, 32'h0);
        c(CMD_DISPLAY, 0);
        want(14, 1, 1);
        sweeping <= 1'b1;
        c(CMD_DISPLAY, 1);
        want(14, 1, 0);
        want(13, 1, 1);
        c(CMD_FUNC, 48'h7, 0);
        want(20, 5, 5'h7);
        want(10, 1, 1);
        c(CMD_KNOB, 0, 0);
        want(11, 1, 1);
        want(20, 5, 5'h7);
        pll <= 1'b1;
        @(posedge clk);
        pll <= 1'b0;
        want(8, 1, 1);
        c(CMD_FAST, 48'h5, 5'hf);
        want(9, 1, 0);
        f = 48'd1000000000;
        c(CMD_FAST, f, 5'ha);
        want(9, 1, 1);
        want(41, 48, f);
        @(posedge clk);
        want(8, 1, 1);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        f = f + 48'(st);
        want(41, 48, f);
        c(CMD_INCR, 0, 0);
        want(41, 48, f);
        c(CMD_FAST, 48'h5, 5'hf);
        want(41, 48, f);
        c(CMD_FUNC, 48'h3, 0);
        c(CMD_INCR, 0, 0);
        f = f + 48'(st);
        want(41, 48, f);
        want(7, 1, 1);
        rd(OFS_CW_LO, f[31:0]);
        c(CMD_BAND, 0, 0);
        want(15, 1, 0);
        wb(1'b1, OFS_CTRL, 32'h7);
        c(CMD_BAND, 0, 0);
        want(15, 1, 1);
        wb(1'b1, OFS_CTRL, 32'h5);
        for (int k = 0; k < 8; k++) begin
            c(CMD_CONFIG, 48'({5'($urandom_range(31)), k[2:0]}));
            want(5, 1, k[0]);
        end
        nonswept <= 1'b1;
        @(posedge clk);
        want(3, 1, 1);
        mid <= 1'b1;
        @(posedge clk);
        mid <= 1'b0;
        want(4, 1, 1);
        c(CMD_BAND, 0, 0);
        want(15, 1, 0);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        want(12, 1, 1);
        c(CMD_BAND, 0, 0);
        want(15, 1, 1);
        c(CMD_FUNC, 0, 0, 1'b1);
        want(2, 1, 0);
        key <= 1'b1;
        repeat (8) if (o[6] !== 1'b1) @(posedge clk);
        key <= 1'b0;
        want(6, 1, 1);
        c(CMD_KBREL, 0, 0);
        want(6, 1, 0);
        c(CMD_CONFIG, 0);
        c(CMD_FUNC, 0, 0, 1'b1);
        want(2, 1, 1);
        alt <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            c(CMD_ALTSEL, 48'(j));
            want(1 - j, 1, 1);
            want(j, 1, 0);
        end
        c(CMD_LEARN, 48'hb);
        want(20, 5, 5'hb);
        recall <= 1'b1;
        @(posedge clk);
        recall <= 1'b0;
        want(20, 5, FUNC_NONE);
        @(posedge clk);
        results();
    end
endmodule // tb_top
